// ==== rtl/ras_pkg.sv ====
// ras_pkg: constants, command and status layouts for the rotate and halt unit.
// assumes a single 250 MHz core clock and a plain strobe register port.
//
// Notes on behaviour
// - rotate left moves msb into carry and old carry into bit 0
// - rotate left result goes to working register if dest is 0, else file
// - rotate right moves lsb into carry and old carry into bit 7
// - rotate right result goes to working register if dest is 0, else file
// - halt clears the powerdown bit and sets the timeout bit
// - halt zeroes the watchdog counter and its prescaler
// - halt then enters sleep with the oscillator enable dropped
package ras_pkg;

  // bus geometry
  localparam int AW      = 8;
  localparam int DW      = 16;
  localparam int FW      = 8;
  localparam int FAW     = 7;
  localparam int FDEPTH  = 128;
  localparam int CMD_W   = 10;
  localparam int ST_W    = 5;

  // register map
  localparam logic [AW-1:0] ADDR_FILE_MAX = 8'h7F;
  localparam logic [AW-1:0] ADDR_WREG     = 8'h80;
  localparam logic [AW-1:0] ADDR_STATUS   = 8'h81;
  localparam logic [AW-1:0] ADDR_CMD      = 8'h82;
  localparam logic [AW-1:0] ADDR_WDT      = 8'h83;
  localparam logic [AW-1:0] ADDR_PRESC    = 8'h84;
  localparam logic [AW-1:0] ADDR_CORE     = 8'h85;

  // status field positions
  localparam int ST_C     = 0;
  localparam int ST_DC    = 1;
  localparam int ST_Z     = 2;
  localparam int ST_PD_N  = 3;
  localparam int ST_TO_N  = 4;

  // core state register field positions
  localparam int CORE_SLEEP = 0;
  localparam int CORE_OSC   = 1;

  // reset values
  localparam logic [FW-1:0]   FILE_RST   = 8'h00;
  localparam logic [FW-1:0]   WREG_RST   = 8'h00;
  localparam logic [ST_W-1:0] STATUS_RST = 5'h18;
  localparam logic [FW-1:0]   WDT_CLR    = 8'h00;
  localparam logic [FW-1:0]   PRESC_CLR  = 8'h00;
  localparam logic [FW-1:0]   PRESC_MAX  = 8'hFF;
  localparam logic [FW-1:0]   ONE8       = 8'h01;
  localparam logic [DW-1:0]   RD_ZERO    = 16'h0000;

  typedef enum logic [1:0] {
    RAS_OP_NONE = 2'b00,
    RAS_OP_ROTL = 2'b01,
    RAS_OP_ROTR = 2'b10,
    RAS_OP_HALT = 2'b11
  } ras_op_e;

  typedef enum logic {
    RAS_ST_RUN   = 1'b0,
    RAS_ST_SLEEP = 1'b1
  } ras_state_e;

  // command word: op in [9:8], dest in [7], file address in [6:0]
  typedef struct packed {
    ras_op_e          op;
    logic             dest;
    logic [FAW-1:0]   faddr;
  } ras_cmd_s;

  typedef struct packed {
    logic to_n;
    logic pd_n;
    logic z;
    logic dc;
    logic c;
  } ras_status_s;

endpackage

// ==== rtl/ras_rotate.sv ====
// ras_rotate: one-position rotate of a byte through the carry flag.
// assumes purely combinational use by the core.
module ras_rotate (
  // operand
  input  wire logic [ras_pkg::FW-1:0] i_data,
  input  wire logic                   i_carry,
  input  wire logic                   i_left,
  // result
  output logic      [ras_pkg::FW-1:0] o_data,
  output logic                        o_carry
);

  logic [ras_pkg::FW-1:0] left_data;
  logic [ras_pkg::FW-1:0] right_data;

  assign left_data  = {i_data[ras_pkg::FW-2:0], i_carry};
  assign right_data = {i_carry, i_data[ras_pkg::FW-1:1]};
  assign o_data     = i_left ? left_data : right_data;
  assign o_carry    = i_left ? i_data[ras_pkg::FW-1] : i_data[0];

endmodule // ras_rotate

// ==== rtl/ras_core.sv ====
// ras_core: file registers, working register, status flags, watchdog and
// sleep control, executing rotate-through-carry and halt commands.
// assumes a master that issues single-cycle strobes and takes read data
// exactly one cycle after the read strobe.
module ras_core (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // register port
  input  wire logic [ras_pkg::AW-1:0]  i_addr,
  input  wire logic [ras_pkg::DW-1:0]  i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [ras_pkg::DW-1:0]  o_rdata,
  // power control
  input  wire logic                    i_wake,
  output logic                         o_sleep,
  output logic                         o_osc_en,
  output logic      [ras_pkg::FW-1:0]  o_wdt_count
);

  // state
  logic [ras_pkg::FW-1:0]   file_r [ras_pkg::FDEPTH];
  logic [ras_pkg::FW-1:0]   wreg_r;
  logic [ras_pkg::FW-1:0]   wreg_nxt;
  ras_pkg::ras_status_s     status_r;
  ras_pkg::ras_status_s     status_nxt;
  logic [ras_pkg::FW-1:0]   wdt_r;
  logic [ras_pkg::FW-1:0]   wdt_nxt;
  logic [ras_pkg::FW-1:0]   presc_r;
  logic [ras_pkg::FW-1:0]   presc_nxt;
  ras_pkg::ras_state_e      state_r;
  ras_pkg::ras_state_e      state_nxt;
  logic [ras_pkg::DW-1:0]   rdata_r;
  logic [ras_pkg::DW-1:0]   rdata_nxt;
  logic                     sleep_r;
  logic                     osc_en_r;

  // decode
  ras_pkg::ras_cmd_s        cmd;
  wire logic                sel_file;
  wire logic                sel_wreg;
  wire logic                sel_status;
  wire logic                sel_cmd;
  wire logic                running;
  wire logic                exec_ok;
  wire logic                do_rotl;
  wire logic                do_rotr;
  wire logic                do_rot;
  wire logic                do_halt;
  wire logic                presc_wrap;

  assign cmd        = ras_pkg::ras_cmd_s'(i_wdata[ras_pkg::CMD_W-1:0]);
  assign sel_file   = (i_addr <= ras_pkg::ADDR_FILE_MAX);
  assign sel_wreg   = (i_addr == ras_pkg::ADDR_WREG);
  assign sel_status = (i_addr == ras_pkg::ADDR_STATUS);
  assign sel_cmd    = (i_addr == ras_pkg::ADDR_CMD);
  assign running    = (state_r == ras_pkg::RAS_ST_RUN);
  // commands are ignored while asleep
  assign exec_ok    = i_wr && sel_cmd && running;
  assign do_rotl    = exec_ok && (cmd.op == ras_pkg::RAS_OP_ROTL);
  assign do_rotr    = exec_ok && (cmd.op == ras_pkg::RAS_OP_ROTR);
  assign do_rot     = do_rotl || do_rotr;
  // halt looks only at the op field
  assign do_halt    = exec_ok && (cmd.op == ras_pkg::RAS_OP_HALT);
  assign presc_wrap = (presc_r == ras_pkg::PRESC_MAX);

  // rotate datapath
  wire logic [ras_pkg::FW-1:0] rot_src;
  logic      [ras_pkg::FW-1:0] rot_data;
  logic                        rot_carry;

  assign rot_src = file_r[cmd.faddr];

  ras_rotate u_rotate (
    .i_data  (rot_src),
    .i_carry (status_r.c),
    .i_left  (do_rotl),
    .o_data  (rot_data),
    .o_carry (rot_carry)
  );

  // write enables
  wire logic                    file_bus_we;
  wire logic                    file_rot_we;
  wire logic [ras_pkg::FAW-1:0] file_waddr;
  wire logic [ras_pkg::FW-1:0]  file_wdata;
  wire logic                    file_we;

  assign file_bus_we = i_wr && sel_file;
  assign file_rot_we = do_rot && cmd.dest;
  assign file_we     = file_bus_we || file_rot_we;
  assign file_waddr  = file_rot_we ? cmd.faddr : i_addr[ras_pkg::FAW-1:0];
  assign file_wdata  = file_rot_we ? rot_data : i_wdata[ras_pkg::FW-1:0];

  // working register takes the rotate result when dest is 0
  assign wreg_nxt = (do_rot && !cmd.dest)     ? rot_data :
                    (i_wr && sel_wreg)        ? i_wdata[ras_pkg::FW-1:0] :
                                                wreg_r;

  // status: software may set c, dc, z; pd_n and to_n are hardware only
  always_comb begin
    status_nxt = status_r;
    if (i_wr && sel_status) begin
      status_nxt.c  = i_wdata[ras_pkg::ST_C];
      status_nxt.dc = i_wdata[ras_pkg::ST_DC];
      status_nxt.z  = i_wdata[ras_pkg::ST_Z];
    end
    if (do_rot) begin
      status_nxt.c = rot_carry;
    end
    if (do_halt) begin
      status_nxt.pd_n = 1'b0;
      status_nxt.to_n = 1'b1;
    end
  end

  // watchdog: prescaler divides the clock, counter steps on its wrap
  assign presc_nxt = do_halt    ? ras_pkg::PRESC_CLR :
                                  presc_r + ras_pkg::ONE8;
  assign wdt_nxt   = do_halt    ? ras_pkg::WDT_CLR :
                     presc_wrap ? wdt_r + ras_pkg::ONE8 :
                                  wdt_r;

  // power state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ras_pkg::RAS_ST_RUN: begin
        if (do_halt) begin
          state_nxt = ras_pkg::RAS_ST_SLEEP;
        end
      end
      ras_pkg::RAS_ST_SLEEP: begin
        if (i_wake) begin
          state_nxt = ras_pkg::RAS_ST_RUN;
        end
      end
      default: begin
        state_nxt = ras_pkg::RAS_ST_RUN;
      end
    endcase
  end

  // read selection
  wire logic [ras_pkg::DW-1:0] rd_file;
  wire logic [ras_pkg::DW-1:0] rd_wreg;
  wire logic [ras_pkg::DW-1:0] rd_status;
  wire logic [ras_pkg::DW-1:0] rd_wdt;
  wire logic [ras_pkg::DW-1:0] rd_presc;
  wire logic [ras_pkg::DW-1:0] rd_core;
  wire logic [ras_pkg::DW-1:0] rd_sel;

  assign rd_file   = {{(ras_pkg::DW-ras_pkg::FW){1'b0}}, file_r[i_addr[ras_pkg::FAW-1:0]]};
  assign rd_wreg   = {{(ras_pkg::DW-ras_pkg::FW){1'b0}}, wreg_r};
  assign rd_status = {{(ras_pkg::DW-ras_pkg::ST_W){1'b0}}, status_r};
  assign rd_wdt    = {{(ras_pkg::DW-ras_pkg::FW){1'b0}}, wdt_r};
  assign rd_presc  = {{(ras_pkg::DW-ras_pkg::FW){1'b0}}, presc_r};
  assign rd_core   = {{(ras_pkg::DW-2){1'b0}}, osc_en_r, sleep_r};
  assign rd_sel    = sel_file                         ? rd_file   :
                     sel_wreg                         ? rd_wreg   :
                     sel_status                       ? rd_status :
                     (i_addr == ras_pkg::ADDR_WDT)    ? rd_wdt    :
                     (i_addr == ras_pkg::ADDR_PRESC)  ? rd_presc  :
                     (i_addr == ras_pkg::ADDR_CORE)   ? rd_core   :
                                                        ras_pkg::RD_ZERO;
  // read data valid only in the cycle after the strobe
  assign rdata_nxt = i_rd ? rd_sel : ras_pkg::RD_ZERO;

  // file register array, one flop group per entry
  genvar gi;
  generate
    for (gi = 0; gi < ras_pkg::FDEPTH; gi++) begin : g_file
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          file_r[gi] <= ras_pkg::FILE_RST;
        end else if (file_we && (file_waddr == ras_pkg::FAW'(gi))) begin
          file_r[gi] <= file_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wreg_r   <= ras_pkg::WREG_RST;
      status_r <= ras_pkg::ras_status_s'(ras_pkg::STATUS_RST);
    end else begin
      wreg_r   <= wreg_nxt;
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdt_r   <= ras_pkg::WDT_CLR;
      presc_r <= ras_pkg::PRESC_CLR;
    end else begin
      wdt_r   <= wdt_nxt;
      presc_r <= presc_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= ras_pkg::RAS_ST_RUN;
      sleep_r  <= 1'b0;
      osc_en_r <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      sleep_r  <= (state_nxt == ras_pkg::RAS_ST_SLEEP);
      osc_en_r <= (state_nxt == ras_pkg::RAS_ST_RUN);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= ras_pkg::RD_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs
  assign o_rdata     = rdata_r;
  assign o_sleep     = sleep_r;
  assign o_osc_en    = osc_en_r;
  assign o_wdt_count = wdt_r;

endmodule // ras_core

// ==== bench/ras_core_properties.sv ====
// ras_core_chk: port-level checks of the rotate and halt unit.
// assumes it is bound to ras_core and sees only that module's ports.
module ras_core_chk (
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  input wire logic [ras_pkg::AW-1:0] i_addr,
  input wire logic [ras_pkg::DW-1:0] i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [ras_pkg::DW-1:0] o_rdata,
  input wire logic                   i_wake,
  input wire logic                   o_sleep,
  input wire logic                   o_osc_en,
  input wire logic [ras_pkg::FW-1:0] o_wdt_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic halt_w;
  logic st_rd_w;
  assign halt_w  = i_wr && i_addr == ras_pkg::ADDR_CMD && i_wdata[9:8] == 2'b11 && !o_sleep;
  assign st_rd_w = i_rd && i_addr == ras_pkg::ADDR_STATUS;
  AST_HALT_SLEEP: assert property (halt_w |=> o_sleep && !o_osc_en)
    else $error("halt did not enter sleep");
  AST_HALT_WDT: assert property (halt_w |=> o_wdt_count == 8'h00)
    else $error("halt did not clear watchdog");
  AST_HALT_STAT: assert property (halt_w ##2 st_rd_w |=> o_rdata[4:3] == 2'b10)
    else $error("status bits wrong after halt");
  AST_OSC_OFF: assert property (o_sleep == !o_osc_en)
    else $error("oscillator enable disagrees with sleep");
  AST_STAY_ASLEEP: assert property (o_sleep && !i_wake |=> $stable(o_sleep))
    else $error("left sleep without wake");
  AST_WAKE: assert property (o_sleep && i_wake |=> !o_sleep && o_osc_en)
    else $error("wake did not restart");
  AST_WDT_STEP: assert property (!halt_w |=> 8'(o_wdt_count - $past(o_wdt_count)) <= 8'h01)
    else $error("watchdog jumped");
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  COV_HALT: cover property (halt_w);
  COV_WAKE: cover property (o_sleep && i_wake);
  COV_STAT: cover property (halt_w ##2 st_rd_w);
endmodule // ras_core_chk

bind ras_core ras_core_chk i_chk (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_wake, .o_sleep, .o_osc_en, .o_wdt_count);

// ==== bench/tb_top.sv ====
// tb_top: directed bench for ras_core over its strobe register port.
// assumes the checker is bound in separately.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_wake = 0;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata;
  logic        o_sleep, o_osc_en;
  logic [7:0]  o_wdt_count;
  int          miscompares = 0, samples_checked = 0, cyc = 0;
  ras_core i_dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_wake, .o_sleep, .o_osc_en, .o_wdt_count);
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic t_reset;
    rd(ras_pkg::ADDR_STATUS, 16'h0018);
    rd(ras_pkg::ADDR_CORE, 16'h0002);
    rd(ras_pkg::ADDR_FILE_MAX, 16'h0000);
    wr(ras_pkg::ADDR_WDT, 16'h0055);
    rd(ras_pkg::ADDR_WDT, 16'h0000);
    wr(8'h90, 16'h00AA);
    rd(8'h90, 16'h0000);
    rd(ras_pkg::ADDR_CMD, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_rotl;
    wr(8'h05, 16'h0096);
    wr(ras_pkg::ADDR_STATUS, 16'h0005);
    wr(ras_pkg::ADDR_CMD, 16'h0185);
    rd(8'h05, 16'h002D);
    rd(ras_pkg::ADDR_STATUS, 16'h001D);
    wr(8'h7F, 16'h0001);
    wr(ras_pkg::ADDR_CMD, 16'h017F);
    rd(ras_pkg::ADDR_WREG, 16'h0003);
    rd(8'h7F, 16'h0001);
    rd(ras_pkg::ADDR_STATUS, 16'h001C);
    $display("test rotate left done");
  endtask
  task automatic t_rotr;
    wr(ras_pkg::ADDR_STATUS, 16'h0002);
    wr(8'h00, 16'h0081);
    wr(ras_pkg::ADDR_CMD, 16'h0280);
    rd(8'h00, 16'h0040);
    rd(ras_pkg::ADDR_STATUS, 16'h001B);
    wr(ras_pkg::ADDR_CMD, 16'h0200);
    rd(ras_pkg::ADDR_WREG, 16'h00A0);
    rd(8'h00, 16'h0040);
    rd(ras_pkg::ADDR_STATUS, 16'h001A);
    $display("test rotate right done");
  endtask
  task automatic t_halt;
    wr(ras_pkg::ADDR_CMD, 16'h03FF);
    #1 chk({14'h0, o_sleep, o_osc_en}, 16'h0002);
    chk({8'h00, o_wdt_count}, 16'h0000);
    rd(ras_pkg::ADDR_STATUS, 16'h0012);
    rd(ras_pkg::ADDR_WDT, 16'h0000);
    rd(ras_pkg::ADDR_PRESC, 16'h0005);
    rd(ras_pkg::ADDR_CORE, 16'h0001);
    rd(8'h7F, 16'h0001);
    rd(ras_pkg::ADDR_WREG, 16'h00A0);
    wr(ras_pkg::ADDR_CMD, 16'h0180);
    rd(8'h00, 16'h0040);
    @(posedge i_clk);
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    #1 chk({14'h0, o_sleep, o_osc_en}, 16'h0001);
    rd(ras_pkg::ADDR_STATUS, 16'h0012);
    // one prescaler wrap since the halt cleared it, well short of a second
    repeat (300) @(posedge i_clk);
    #1 chk({8'h00, o_wdt_count}, 16'h0001);
    $display("test halt done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_rotl();
    t_rotr();
    t_halt();
    results();
  end
endmodule // tb_top
